// >>> design/sbrg_pkg.sv
package sbrg_pkg;
  localparam int unsigned SBRG_CLK_HZ = 100000000;
  localparam int unsigned SBRG_OVERSAMPLE = 16;
  localparam logic [7:0] SBRG_OFF_DIV_HIGH = 8'h00;
  localparam logic [7:0] SBRG_OFF_DIV_LOW = 8'h04;
  localparam logic [7:0] SBRG_OFF_CTRL2 = 8'h08;
  localparam logic [7:0] SBRG_OFF_OPTIONS = 8'h0C;
  localparam logic [7:0] SBRG_OFF_IRQ_STATUS = 8'h10;
  localparam logic [7:0] SBRG_OFF_IRQ_MASK = 8'h14;
  localparam logic [7:0] SBRG_OFF_STATUS = 8'h18;
  localparam int unsigned SBRG_HIGH_BREAK_IE_BIT = 7;
  localparam int unsigned SBRG_HIGH_EDGE_IE_BIT = 6;
  localparam int unsigned SBRG_CTRL2_RX_EN_BIT = 2;
  localparam int unsigned SBRG_CTRL2_TX_EN_BIT = 3;
  localparam int unsigned SBRG_OPT_PORT_SEL_BIT = 0;
  localparam int unsigned SBRG_IRQ_BREAK_BIT = 0;
  localparam int unsigned SBRG_IRQ_EDGE_BIT = 1;
  localparam logic [7:0] SBRG_DIV_HIGH_RESET = 8'h00;
  localparam logic [7:0] SBRG_DIV_LOW_RESET = 8'h04;
  localparam logic [7:0] SBRG_DIV_HIGH_WMASK = 8'hDF;
  localparam logic [1:0] SBRG_RESP_OKAY = 2'b00;
  localparam logic [1:0] SBRG_RESP_SLVERR = 2'b10;

  typedef struct packed {
    logic [4:0] high;
    logic [7:0] low;
  } sbrg_divisor_t;

  typedef struct packed {
    logic [31:0] data;
    logic [1:0] resp;
  } sbrg_read_t;

  typedef enum logic [2:0] {
    SBRG_IDLE = 3'b001,
    SBRG_RUN = 3'b010,
    SBRG_STOP = 3'b100
  } sbrg_state_t;
endpackage

// >>> design/sbrg_core.sv
`timescale 1ns/1ps
module sbrg_core
  import sbrg_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic line_break_detect_flag,
  input wire logic rx_edge_flag,
  output logic oversample_tick,
  output logic bit_tick,
  output logic second_port_position_select,
  output logic irq
);

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    return a[7:2] == off[7:2];
  endfunction

  logic [7:0] high_buf_reg;
  logic [7:0] high_work_reg;
  logic [7:0] low_reg;
  logic [7:0] ctrl2_reg;
  logic port_sel_reg;
  logic [1:0] irq_status_reg;
  logic [1:0] irq_mask_reg;
  logic [7:0] aw_addr_reg;
  logic aw_full_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic w_full_reg;
  logic [12:0] div_cnt_reg;
  logic [3:0] os_cnt_reg;
  logic oversample_tick_reg;
  logic bit_tick_reg;
  logic armed_reg;
  logic break_flag_reg;
  logic edge_flag_reg;
  sbrg_state_t state_reg;
  sbrg_state_t state_next;
  sbrg_divisor_t divisor;
  sbrg_read_t rd;
  logic wr_go;
  logic wr_high;
  logic wr_low;
  logic wr_ctrl2;
  logic [1:0] events;
  logic [1:0] w1c;

  assign divisor = '{high: high_work_reg[4:0], low: low_reg};

  // write channel: address and data accepted independently, one write in flight
  assign s_axi_awready = !aw_full_reg && !s_axi_bvalid;
  assign s_axi_wready = !w_full_reg && !s_axi_bvalid;
  assign wr_go = aw_full_reg && w_full_reg && !s_axi_bvalid;
  assign wr_high = wr_go && hit(aw_addr_reg, SBRG_OFF_DIV_HIGH) && w_strb_reg[0];
  assign wr_low = wr_go && hit(aw_addr_reg, SBRG_OFF_DIV_LOW) && w_strb_reg[0];
  assign wr_ctrl2 = wr_go && hit(aw_addr_reg, SBRG_OFF_CTRL2) && w_strb_reg[0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_full_reg <= 1'b1;
      aw_addr_reg <= s_axi_awaddr;
    end else if (wr_go) begin
      aw_full_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_full_reg <= 1'b0;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_full_reg <= 1'b1;
      w_data_reg <= s_axi_wdata;
      w_strb_reg <= s_axi_wstrb;
    end else if (wr_go) begin
      w_full_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= SBRG_RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (aw_addr_reg > SBRG_OFF_STATUS + 8'h03) ? SBRG_RESP_SLVERR : SBRG_RESP_OKAY;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      high_buf_reg <= SBRG_DIV_HIGH_RESET;
    end else if (wr_high) begin
      high_buf_reg <= w_data_reg[7:0] & SBRG_DIV_HIGH_WMASK;
    end
  end

  // both halves load together on low write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      high_work_reg <= SBRG_DIV_HIGH_RESET;
      low_reg <= SBRG_DIV_LOW_RESET;
    end else if (wr_low) begin
      high_work_reg <= high_buf_reg;
      low_reg <= w_data_reg[7:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl2_reg <= 8'h00;
      port_sel_reg <= 1'b0;
      irq_mask_reg <= 2'b00;
    end else if (wr_go && w_strb_reg[0]) begin
      if (wr_ctrl2) begin
        ctrl2_reg <= w_data_reg[7:0];
      end
      if (hit(aw_addr_reg, SBRG_OFF_OPTIONS)) begin
        port_sel_reg <= w_data_reg[SBRG_OPT_PORT_SEL_BIT];
      end
      if (hit(aw_addr_reg, SBRG_OFF_IRQ_MASK)) begin
        irq_mask_reg <= w_data_reg[1:0];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      armed_reg <= 1'b0;
    end else if (wr_ctrl2 && (w_data_reg[SBRG_CTRL2_RX_EN_BIT] || w_data_reg[SBRG_CTRL2_TX_EN_BIT])) begin
      armed_reg <= 1'b1;
    end
  end

  assign second_port_position_select = port_sel_reg;

  // flags come from other logic; sticky events taken on rising edge, set beats clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      break_flag_reg <= 1'b0;
      edge_flag_reg <= 1'b0;
    end else begin
      break_flag_reg <= line_break_detect_flag;
      edge_flag_reg <= rx_edge_flag;
    end
  end

  assign events = {rx_edge_flag & ~edge_flag_reg, line_break_detect_flag & ~break_flag_reg};
  assign w1c = (wr_go && w_strb_reg[0] && hit(aw_addr_reg, SBRG_OFF_IRQ_STATUS)) ? w_data_reg[1:0] : 2'b00;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_status_reg <= 2'b00;
    end else begin
      irq_status_reg <= (irq_status_reg & ~w1c) | events;
    end
  end

  // level requests from enabled flags, plus masked sticky events
  assign irq = (high_work_reg[SBRG_HIGH_BREAK_IE_BIT] && line_break_detect_flag)
    || (high_work_reg[SBRG_HIGH_EDGE_IE_BIT] && rx_edge_flag)
    || |(irq_status_reg & irq_mask_reg);

  // read channel
  assign s_axi_arready = !s_axi_rvalid;

  always_comb begin
    rd = '{data: 32'h0000_0000, resp: SBRG_RESP_OKAY};
    if (hit(s_axi_araddr, SBRG_OFF_DIV_HIGH)) begin
      rd.data[7:0] = high_work_reg;
    end else if (hit(s_axi_araddr, SBRG_OFF_DIV_LOW)) begin
      rd.data[7:0] = low_reg;
    end else if (hit(s_axi_araddr, SBRG_OFF_CTRL2)) begin
      rd.data[7:0] = ctrl2_reg;
    end else if (hit(s_axi_araddr, SBRG_OFF_OPTIONS)) begin
      rd.data[SBRG_OPT_PORT_SEL_BIT] = port_sel_reg;
    end else if (hit(s_axi_araddr, SBRG_OFF_IRQ_STATUS)) begin
      rd.data[1:0] = irq_status_reg;
    end else if (hit(s_axi_araddr, SBRG_OFF_IRQ_MASK)) begin
      rd.data[1:0] = irq_mask_reg;
    end else if (hit(s_axi_araddr, SBRG_OFF_STATUS)) begin
      rd.data[3:0] = state_reg == SBRG_RUN ? {os_cnt_reg[2:0], 1'b1} : 4'h0;
    end else begin
      rd.resp = SBRG_RESP_SLVERR;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= SBRG_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd.data;
      s_axi_rresp <= rd.resp;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  always_comb begin
    case (state_reg)
      SBRG_IDLE: state_next = armed_reg ? (divisor == '0 ? SBRG_STOP : SBRG_RUN) : SBRG_IDLE;
      SBRG_RUN: state_next = divisor == '0 ? SBRG_STOP : SBRG_RUN;
      SBRG_STOP: state_next = divisor == '0 ? SBRG_STOP : SBRG_RUN;
      default: state_next = SBRG_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= SBRG_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // modulo count of bus clocks; a divisor reload restarts the count
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_cnt_reg <= 13'h0000;
      os_cnt_reg <= 4'h0;
      oversample_tick_reg <= 1'b0;
      bit_tick_reg <= 1'b0;
    end else if (state_reg != SBRG_RUN || wr_low) begin
      div_cnt_reg <= 13'h0000;
      os_cnt_reg <= 4'h0;
      oversample_tick_reg <= 1'b0;
      bit_tick_reg <= 1'b0;
    end else if (div_cnt_reg == divisor - 13'h0001) begin
      div_cnt_reg <= 13'h0000;
      os_cnt_reg <= os_cnt_reg + 4'h1;
      oversample_tick_reg <= 1'b1;
      bit_tick_reg <= os_cnt_reg == 4'(SBRG_OVERSAMPLE - 1);
    end else begin
      div_cnt_reg <= div_cnt_reg + 13'h0001;
      oversample_tick_reg <= 1'b0;
      bit_tick_reg <= 1'b0;
    end
  end

  assign oversample_tick = oversample_tick_reg;
  assign bit_tick = bit_tick_reg;

  property p_high_buffered;
    @(posedge aclk) disable iff (!aresetn)
    (wr_high && !wr_low) |=> $stable(high_work_reg);
  endproperty
  a_high_buffered: assert property (p_high_buffered) else $error("high divisor changed without low write");

  property p_load_together;
    @(posedge aclk) disable iff (!aresetn)
    wr_low |=> (high_work_reg == $past(high_buf_reg)) && (low_reg == $past(w_data_reg[7:0]));
  endproperty
  a_load_together: assert property (p_load_together) else $error("halves not loaded together");

  property p_idle_until_armed;
    @(posedge aclk) disable iff (!aresetn)
    !armed_reg |-> !oversample_tick && state_reg == SBRG_IDLE;
  endproperty
  a_idle_until_armed: assert property (p_idle_until_armed) else $error("generator ran before enable");

  property p_zero_stops;
    @(posedge aclk) disable iff (!aresetn)
    (divisor == '0) [*2] |-> !oversample_tick;
  endproperty
  a_zero_stops: assert property (p_zero_stops) else $error("ticks with zero divisor");

  // divisor one: a tick on every bus clock
  property p_tick_spacing_one;
    @(posedge aclk) disable iff (!aresetn)
    (oversample_tick && divisor == 13'h0001 && state_reg == SBRG_RUN && !wr_low) |=> oversample_tick;
  endproperty
  a_tick_spacing_one: assert property (p_tick_spacing_one) else $error("oversample ticks not back to back");

  property p_tick_period;
    @(posedge aclk) disable iff (!aresetn)
    (oversample_tick && divisor == 13'h0002 && $stable(divisor) && state_reg == SBRG_RUN && !wr_low)
      |=> !oversample_tick ##1 (oversample_tick || $past(wr_low) || $past(divisor) != 13'h0002
      || $past(state_reg) != SBRG_RUN);
  endproperty
  a_tick_period: assert property (p_tick_period) else $error("oversample period wrong");

  property p_bit_sixteen;
    @(posedge aclk) disable iff (!aresetn)
    bit_tick |-> oversample_tick && $past(os_cnt_reg) == 4'hF;
  endproperty
  a_bit_sixteen: assert property (p_bit_sixteen) else $error("bit tick not on sixteenth");

  property p_pack;
    @(posedge aclk) disable iff (!aresetn)
    divisor == {high_work_reg[4:0], low_reg};
  endproperty
  a_pack: assert property (p_pack) else $error("divisor packing wrong");

  property p_break_irq;
    @(posedge aclk) disable iff (!aresetn)
    (high_work_reg[SBRG_HIGH_BREAK_IE_BIT] && line_break_detect_flag) |-> irq;
  endproperty
  a_break_irq: assert property (p_break_irq) else $error("break interrupt missing");

  property p_edge_irq;
    @(posedge aclk) disable iff (!aresetn)
    (high_work_reg[SBRG_HIGH_EDGE_IE_BIT] && rx_edge_flag) |-> irq;
  endproperty
  a_edge_irq: assert property (p_edge_irq) else $error("edge interrupt missing");

  property p_port_sel;
    @(posedge aclk) disable iff (!aresetn)
    (wr_go && w_strb_reg[0] && hit(aw_addr_reg, SBRG_OFF_OPTIONS))
      |=> second_port_position_select == $past(w_data_reg[0]);
  endproperty
  a_port_sel: assert property (p_port_sel) else $error("port select not written");

endmodule // sbrg_core

// >>> verification/sbrg_far_model.sv
`timescale 1ns/1ps
// remote transceiver side: a break or an active edge is reported one bus clock
// after the bench asks for it, and holds as long as the condition lasts
module sbrg_far_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic hold_break,
  input wire logic hold_edge,
  output logic line_break_detect_flag,
  output logic rx_edge_flag
);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      line_break_detect_flag <= 1'b0;
      rx_edge_flag <= 1'b0;
    end else begin
      line_break_detect_flag <= hold_break;
      rx_edge_flag <= hold_edge;
    end
  end
endmodule // sbrg_far_model

// >>> verification/tb.sv
`timescale 1ns/1ps
module tb
  import sbrg_pkg::*;
;
  typedef struct packed {
    logic [7:0] hi;
    logic [7:0] lo;
    logic [31:0] gap;
    logic bit_chk;
  } sbrg_row_t;
  // bit spacing only checked where 16 x divisor keeps the run short
  sbrg_row_t rows [0:4] = '{'{8'h00, 8'h01, 32'h1, 1'b1}, '{8'h00, 8'h02, 32'h2, 1'b1},
    '{8'h00, 8'h05, 32'h5, 1'b1}, '{8'h01, 8'h03, 32'h103, 1'b0}, '{8'h1F, 8'hFF, 32'h1FFF, 1'b0}};
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic s_axi_awvalid = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic [7:0] s_axi_araddr = 8'h00;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic hold_break = 1'b0;
  logic hold_edge = 1'b0;
  logic line_break_detect_flag, rx_edge_flag;
  logic oversample_tick, bit_tick, second_port_position_select, irq;
  int fails = 0;
  int cmp_count = 0;

  always #5 aclk = ~aclk;

  sbrg_far_model i_far (.aclk(aclk), .aresetn(aresetn), .hold_break(hold_break), .hold_edge(hold_edge),
    .line_break_detect_flag(line_break_detect_flag), .rx_edge_flag(rx_edge_flag));

  sbrg_core i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .line_break_detect_flag(line_break_detect_flag), .rx_edge_flag(rx_edge_flag),
    .oversample_tick(oversample_tick), .bit_tick(bit_tick),
    .second_port_position_select(second_port_position_select), .irq(irq));

  task close_out;
    if (fails == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task axw(input logic [7:0] a, input logic [31:0] dat, output logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= dat;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    // no cycle count assumed; only the watchdog ends a stuck wait
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  function automatic logic tk(input bit bt);
    return bt ? bit_tick : oversample_tick;
  endfunction

  // cycles between two consecutive ticks, sampled on the falling edge
  task gap(input bit bt, output int g);
    int n;
    n = 0;
    g = 1;
    do begin
      @(negedge aclk);
      n++;
    end while (tk(bt) !== 1'b1 && n < 20000);
    @(negedge aclk);
    while (tk(bt) !== 1'b1 && g < 20000) begin
      @(negedge aclk);
      g++;
    end
  endtask

  task cnt(input int n, output int c);
    c = 0;
    repeat (n) begin
      @(negedge aclk);
      if (oversample_tick !== 1'b0) c++;
    end
  endtask

  task setdiv(input logic [7:0] hi, input logic [7:0] lo);
    logic [1:0] r;
    axw(SBRG_OFF_DIV_HIGH, {24'h0, hi}, r);
    axw(SBRG_OFF_DIV_LOW, {24'h0, lo}, r);
  endtask

  initial begin
    // the longest row needs about two slow periods; the whole run stays near 20k cycles
    #400000;
    fails++;
    close_out();
  end

  initial begin
    logic [31:0] d;
    logic [1:0] r;
    int g;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    chk({31'h0, second_port_position_select}, 32'h0);
    chk({31'h0, irq}, 32'h0);
    axr(SBRG_OFF_DIV_HIGH, d, r);
    chk(d, {24'h0, SBRG_DIV_HIGH_RESET});
    axr(SBRG_OFF_DIV_LOW, d, r);
    chk(d, {24'h0, SBRG_DIV_LOW_RESET});
    cnt(100, g);
    chk(g, 0);
    axw(SBRG_OFF_CTRL2, 32'h4, r);
    for (int i = 0; i < 5; i++) begin
      setdiv(rows[i].hi, rows[i].lo);
      axr(SBRG_OFF_DIV_HIGH, d, r);
      chk({27'h0, d[4:0]}, {27'h0, rows[i].hi[4:0]});
      gap(1'b0, g);
      chk(g, rows[i].gap);
      if (rows[i].bit_chk) begin
        gap(1'b1, g);
        chk(g, rows[i].gap * 16);
      end
    end
    // a lone high write must leave the running divisor alone
    setdiv(8'h00, 8'h02);
    axw(SBRG_OFF_DIV_HIGH, 32'h1, r);
    axr(SBRG_OFF_DIV_HIGH, d, r);
    chk({27'h0, d[4:0]}, 32'h0);
    gap(1'b0, g);
    chk(g, 2);
    axw(SBRG_OFF_DIV_LOW, 32'h0, r);
    gap(1'b0, g);
    chk(g, 32'h100);
    setdiv(8'h00, 8'h00);
    cnt(100, g);
    chk(g, 0);
    axr(SBRG_OFF_STATUS, d, r);
    chk({31'h0, d[0]}, 32'h0);
    setdiv(8'h80, 8'h04);
    @(posedge aclk);
    hold_break <= 1'b1;
    repeat (3) @(negedge aclk);
    chk({31'h0, irq}, 32'h1);
    @(posedge aclk);
    hold_break <= 1'b0;
    repeat (3) @(negedge aclk);
    chk({31'h0, irq}, 32'h0);
    setdiv(8'h40, 8'h04);
    @(posedge aclk);
    hold_edge <= 1'b1;
    repeat (3) @(negedge aclk);
    chk({31'h0, irq}, 32'h1);
    setdiv(8'h00, 8'h04);
    @(negedge aclk);
    chk({31'h0, irq}, 32'h0);
    @(posedge aclk);
    hold_edge <= 1'b0;
    // sticky status, mask and write-one-to-clear
    axr(SBRG_OFF_IRQ_STATUS, d, r);
    chk(d & 32'h3, 32'h3);
    axw(SBRG_OFF_IRQ_MASK, 32'h1, r);
    @(negedge aclk);
    chk({31'h0, irq}, 32'h1);
    axw(SBRG_OFF_IRQ_STATUS, 32'h1, r);
    @(negedge aclk);
    chk({31'h0, irq}, 32'h0);
    axr(SBRG_OFF_IRQ_STATUS, d, r);
    chk(d & 32'h3, 32'h2);
    axw(SBRG_OFF_OPTIONS, 32'h1, r);
    @(negedge aclk);
    chk({31'h0, second_port_position_select}, 32'h1);
    axw(SBRG_OFF_OPTIONS, 32'h0, r);
    @(negedge aclk);
    chk({31'h0, second_port_position_select}, 32'h0);
    axw(8'h20, 32'h5, r);
    chk({30'h0, r}, {30'h0, SBRG_RESP_SLVERR});
    axr(SBRG_OFF_DIV_LOW, d, r);
    chk(d, 32'h4);
    axr(8'h20, d, r);
    chk({30'h0, r}, {30'h0, SBRG_RESP_SLVERR});
    chk(d, 32'h0);
    // mid-run reset with the generator ticking every cycle
    setdiv(8'h00, 8'h01);
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    chk({31'h0, oversample_tick}, 32'h0);
    axr(SBRG_OFF_DIV_LOW, d, r);
    chk(d, {24'h0, SBRG_DIV_LOW_RESET});
    cnt(50, g);
    chk(g, 0);
    // transmitter enable alone must arm it as well
    axw(SBRG_OFF_CTRL2, 32'h8, r);
    gap(1'b0, g);
    chk(g, {24'h0, SBRG_DIV_LOW_RESET});
    close_out();
  end
endmodule // tb
